//--- hdl/bnip_regs.vh
// Register map, field positions and reset values of the pending-flag block
`ifndef BNIP_REGS_VH
`define BNIP_REGS_VH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define BNIP_OFF_LINK_PEND 5'h00
`define BNIP_OFF_PIN_PEND 5'h04
`define BNIP_OFF_LINK_MASK 5'h08
`define BNIP_OFF_PIN_MASK 5'h0C
`define BNIP_OFF_ERR_CTRL 5'h10
`define BNIP_OFF_ERR_CNT 5'h14
`define BNIP_OFF_NODE_CTRL 5'h18
`define BNIP_OFF_IRQ_STAT 5'h1C

// ----------------------------------------------------------------
// Link error pending fields
// ----------------------------------------------------------------
`define BNIP_LE_RESP_CRC 7
`define BNIP_LE_MISSED 6
`define BNIP_LE_THRESH 5
`define BNIP_LE_PWR 4
`define BNIP_LE_PARITY 3
`define BNIP_LE_CRC 2
`define BNIP_LE_DECODE 1
`define BNIP_LE_HDRCNT 0

// ----------------------------------------------------------------
// Pin event pending fields and other fields
// ----------------------------------------------------------------
`define BNIP_PIN_LO 2
`define BNIP_PIN_HI 7
`define BNIP_PIN_ZERO 0
`define BNIP_LIMIT_HI 7
`define BNIP_LIMIT_LO 5
`define BNIP_SOFT_RST 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BNIP_RST_PEND 8'h00
`define BNIP_RST_MASK 8'h00
`define BNIP_RST_LIMIT 3'h0
`define BNIP_RST_CNT 9'h000

`endif

//--- hdl/bnip_sync.v
// Three-stage pin synchroniser with agreement filter and rise detect
`timescale 1ns/10ps

module bnip_sync (
   input wire core_clk,           // System clock
   input wire rst_b,              // Synchronous reset, active low
   input wire [7:0] pin_async,    // Raw pin levels
   output wire [7:0] pin_level,   // Filtered level
   output wire [7:0] pin_rise     // One-cycle pulse on filtered rise
);

   reg [7:0] s1_r;
   reg [7:0] s2_r;
   reg [7:0] s3_r;
   reg [7:0] level_r;
   reg [7:0] rise_r;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always @(posedge core_clk) begin
            if (!rst_b) begin
               s1_r[i] <= 1'b0;
               s2_r[i] <= 1'b0;
               s3_r[i] <= 1'b0;
               level_r[i] <= 1'b0;
               rise_r[i] <= 1'b0;
            end else begin
               s1_r[i] <= pin_async[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               // A change counts only once stages two and three agree
               if (s2_r[i] == s3_r[i]) begin
                  level_r[i] <= s3_r[i];
               end
               rise_r[i] <= (s2_r[i] == s3_r[i]) & s3_r[i] & ~level_r[i];
            end
         end
      end
   endgenerate

   assign pin_level = level_r;
   assign pin_rise = rise_r;

endmodule

//--- hdl/bnip_top.v
// Bus node interrupt pending flags with Avalon-MM register access
`timescale 1ns/10ps
`include "bnip_regs.vh"

// How it works
// - Missed upstream response frame sets link pending bit 6 until cleared by one.
// - Error count reaching selected limit sets link pending bit 5; write one clears.
// - Downstream power switch error sets link pending bit 4; write one clears.
// - Parity error in a consumed slot sets link pending bit 3; others ignored.
// - Frame CRC error sets bit 2: upstream frame as master, downstream frame as slave.
// - Decoding error in a consumed slot sets link pending bit 1.
// - Header count mismatch in a response frame sets link pending bit 0.
// - Pin 7 request sets pin pending bit 7 until written with one.
// - Pin 6 request sets pin pending bit 6; write one clears.
// - Pin 5 request sets pin pending bit 5; write one clears.
// - Pin 4 request sets pin pending bit 4; write one clears.
// - Pin 3 request sets pin pending bit 3; write one clears.
// - Pin 2 request sets pin pending bit 2; write one clears.
// - Slave-role upstream response frame CRC error sets link pending bit 7.
// - Pin pending bit 0 reads zero in master role.
// - Three-bit limit code n selects two to the power n+1 errors.
// - Only flags with their mask bit set raise the interrupt; all still latch.
module bnip_top (
   input wire core_clk,                    // System clock, 250 MHz
   input wire rst_b,                       // Synchronous reset, active low
   input wire [4:0] avs_address,           // Byte address
   input wire avs_read,                    // Read request
   input wire avs_write,                   // Write request
   input wire [31:0] avs_writedata,        // Write data
   input wire [3:0] avs_byteenable,        // Byte enables
   output wire [31:0] avs_readdata,        // Read data
   output wire avs_waitrequest,            // Stall until answer
   input wire master_role,                 // High when node is master
   input wire missed_frame_evt,            // Response frame missed its slot
   input wire link_err_evt,                // One counted link error
   input wire pwr_switch_err_evt,          // Downstream power switch error
   input wire parity_err_evt,              // Parity error in a data slot
   input wire decode_err_evt,              // Decoding error in a data slot
   input wire slot_consumed,               // Current slot is consumed here
   input wire resp_frame_crc_evt,          // CRC error, upstream response frame
   input wire ctrl_frame_crc_evt,          // CRC error, downstream control frame
   input wire header_count_err_evt,        // Header count mismatch
   input wire [7:0] gpio_pin,              // Asynchronous general-purpose pins
   output wire irq                         // Level interrupt, active high
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg ack_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;
   reg [7:0] link_pend_r;
   reg [7:0] link_pend_nxt;
   reg [7:0] pin_pend_r;
   reg [7:0] pin_pend_nxt;
   reg [7:0] link_mask_r;
   reg [7:0] pin_mask_r;
   reg [2:0] limit_sel_r;
   reg [8:0] err_cnt_r;
   reg [8:0] err_cnt_nxt;
   reg thresh_hit;
   reg soft_rst_r;
   wire wr_en;
   wire [7:0] wr_byte;
   wire [7:0] pin_level;
   wire [7:0] pin_rise;
   wire [7:0] link_set;
   wire [7:0] pin_set;
   wire [7:0] link_clr;
   wire [7:0] pin_clr;
   wire [7:0] pin_view;
   wire [8:0] err_limit;
   wire flags_clear;
   wire wr_link_pend;
   wire wr_pin_pend;
   wire wr_link_mask;
   wire wr_pin_mask;
   wire wr_err_ctrl;
   wire wr_err_cnt;
   wire wr_node_ctrl;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function hit;
      input [4:0] addr;
      input [4:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // Error limit: code n gives 2 << n errors
   function [8:0] limit_of;
      input [2:0] code;
      begin
         limit_of = 9'h002 << code;
      end
   endfunction

   // Next value of a write-one-to-clear flag byte; a new event beats a clear
   function [7:0] w1c_next;
      input [7:0] cur;
      input [7:0] set;
      input [7:0] clr;
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            if (set[k]) begin
               w1c_next[k] = 1'b1;
            end else if (clr[k]) begin
               w1c_next[k] = 1'b0;
            end else begin
               w1c_next[k] = cur[k];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // Every access stalls exactly one cycle; the write lands and the
   // read data stands on the edge where waitrequest is low.
   always @(posedge core_clk) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   // Only byte lane zero holds writable bits; the other lanes are ignored on writes
   assign wr_en = avs_write & ack_r & avs_byteenable[0];
   assign wr_byte = avs_writedata[7:0];

   // ----------------------------------------------------------------
   // Register write strobes
   // ----------------------------------------------------------------
   assign wr_link_pend = wr_en & hit(avs_address, `BNIP_OFF_LINK_PEND);
   assign wr_pin_pend = wr_en & hit(avs_address, `BNIP_OFF_PIN_PEND);
   assign wr_link_mask = wr_en & hit(avs_address, `BNIP_OFF_LINK_MASK);
   assign wr_pin_mask = wr_en & hit(avs_address, `BNIP_OFF_PIN_MASK);
   assign wr_err_ctrl = wr_en & hit(avs_address, `BNIP_OFF_ERR_CTRL);
   assign wr_err_cnt = wr_en & hit(avs_address, `BNIP_OFF_ERR_CNT);
   assign wr_node_ctrl = wr_en & hit(avs_address, `BNIP_OFF_NODE_CTRL);

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   // A pin request counts only after the filter sees two agreeing samples
   bnip_sync u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_async(gpio_pin),
      .pin_level(pin_level),
      .pin_rise(pin_rise)
   );

   // ----------------------------------------------------------------
   // Error counter and threshold
   // ----------------------------------------------------------------
   assign err_limit = limit_of(limit_sel_r);

   always @* begin
      err_cnt_nxt = err_cnt_r;
      thresh_hit = 1'b0;
      // Saturates at the top so a long burst cannot wrap below the limit
      if (link_err_evt && (err_cnt_r != 9'h1FF)) begin
         err_cnt_nxt = err_cnt_r + 9'h001;
      end
      // Flag when the count reaches the selected limit
      if (link_err_evt && (err_cnt_nxt == err_limit) && (err_cnt_r != err_limit)) begin
         thresh_hit = 1'b1;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_b || flags_clear) begin
         err_cnt_r <= `BNIP_RST_CNT;
      end else if (wr_err_cnt) begin
         err_cnt_r <= `BNIP_RST_CNT;
      end else begin
         err_cnt_r <= err_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   assign link_set[`BNIP_LE_RESP_CRC] = resp_frame_crc_evt & ~master_role;
   assign link_set[`BNIP_LE_MISSED] = missed_frame_evt;
   assign link_set[`BNIP_LE_THRESH] = thresh_hit;
   assign link_set[`BNIP_LE_PWR] = pwr_switch_err_evt;
   assign link_set[`BNIP_LE_PARITY] = parity_err_evt & slot_consumed;
   assign link_set[`BNIP_LE_CRC] = master_role ? resp_frame_crc_evt :
                                   ctrl_frame_crc_evt;
   assign link_set[`BNIP_LE_DECODE] = decode_err_evt & slot_consumed;
   assign link_set[`BNIP_LE_HDRCNT] = header_count_err_evt;

   genvar p;
   generate
      for (p = `BNIP_PIN_LO; p <= `BNIP_PIN_HI; p = p + 1) begin : g_pin
         assign pin_set[p] = pin_rise[p];
      end
   endgenerate
   assign pin_set[1] = 1'b0;
   assign pin_set[`BNIP_PIN_ZERO] = pin_rise[`BNIP_PIN_ZERO] & ~master_role;

   // ----------------------------------------------------------------
   // Write-one-to-clear pending flags
   // ----------------------------------------------------------------
   assign link_clr = wr_link_pend ? wr_byte : 8'h00;
   assign pin_clr = wr_pin_pend ? wr_byte : 8'h00;
   assign flags_clear = soft_rst_r;

   always @* begin
      // Zero bits in the write leave a flag alone; set beats clear
      link_pend_nxt = w1c_next(link_pend_r, link_set, link_clr);
      pin_pend_nxt = w1c_next(pin_pend_r, pin_set, pin_clr);
   end

   always @(posedge core_clk) begin
      if (!rst_b || flags_clear) begin
         link_pend_r <= `BNIP_RST_PEND;
         pin_pend_r <= `BNIP_RST_PEND;
      end else begin
         link_pend_r <= link_pend_nxt;
         pin_pend_r <= pin_pend_nxt;
      end
   end

   // Master role hides the pin zero flag from reads and from the interrupt
   assign pin_view = master_role ? (pin_pend_r & 8'hFE) : pin_pend_r;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rst_b || flags_clear) begin
         link_mask_r <= `BNIP_RST_MASK;
         pin_mask_r <= `BNIP_RST_MASK;
         limit_sel_r <= `BNIP_RST_LIMIT;
      end else begin
         if (wr_link_mask) begin
            link_mask_r <= wr_byte;
         end
         if (wr_pin_mask) begin
            pin_mask_r <= wr_byte;
         end
         if (wr_err_ctrl) begin
            limit_sel_r <= wr_byte[`BNIP_LIMIT_HI:`BNIP_LIMIT_LO];
         end
      end
   end

   // Soft reset is a self-clearing pulse
   always @(posedge core_clk) begin
      if (!rst_b) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_node_ctrl & wr_byte[`BNIP_SOFT_RST];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // Level output: high while any enabled flag is pending
   assign irq = |(link_pend_r & link_mask_r) | |(pin_view & pin_mask_r);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always @* begin
      rdata_nxt = 32'h00000000;
      case (avs_address)
         `BNIP_OFF_LINK_PEND: rdata_nxt[7:0] = link_pend_r;
         `BNIP_OFF_PIN_PEND: rdata_nxt[7:0] = pin_view;
         `BNIP_OFF_LINK_MASK: rdata_nxt[7:0] = link_mask_r;
         `BNIP_OFF_PIN_MASK: rdata_nxt[7:0] = pin_mask_r;
         `BNIP_OFF_ERR_CTRL: rdata_nxt[7:5] = limit_sel_r;
         `BNIP_OFF_ERR_CNT: rdata_nxt[8:0] = err_cnt_r;
         `BNIP_OFF_IRQ_STAT: rdata_nxt[0] = irq;
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Captured on the stall cycle so it stands at the answering edge
   always @(posedge core_clk) begin
      if (!rst_b) begin
         rdata_r <= 32'h00000000;
      end else if (avs_read && !ack_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_readdata = rdata_r;

endmodule

//--- tb/bnip_monitor.sv
// Port checker for the pending-flag block
`timescale 1ns/10ps
module bnip_monitor (
   input wire core_clk,            // System clock
   input wire rst_b,               // Synchronous reset, active low
   input wire [4:0] avs_address,   // Byte address
   input wire avs_read,            // Read request
   input wire avs_write,           // Write request
   input wire [31:0] avs_readdata, // Read data
   input wire avs_waitrequest,     // Bus stall
   input wire master_role,         // High in master role
   input wire irq                  // Level interrupt
);
   wire rd_ack;
   wire wr_ack;
   assign rd_ack = avs_read && !avs_waitrequest;
   assign wr_ack = avs_write && !avs_waitrequest;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_wait_once:
      assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("request not answered after exactly one wait cycle");
   a_idle_no_wait:
      assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   a_reset_irq_low:
      assert property ($rose(rst_b) |-> !irq ##1 !irq)
      else $error("interrupt high right after reset");
   a_link_upper_zero:
      assert property (rd_ack && avs_address == 5'h00 |-> avs_readdata[31:8] == 24'h000000)
      else $error("link pending read has upper bits set");
   a_pin0_master:
      assert property (rd_ack && avs_address == 5'h04 && master_role |-> !avs_readdata[0])
      else $error("pin zero flag set in master role");
   a_irq_fall_cause:
      assert property ($fell(irq) |-> $past(wr_ack) || $past(wr_ack, 2) || $past(!rst_b))
      else $error("interrupt dropped without a write");
   a_data_stays:
      assert property (!avs_read ##1 !avs_read |-> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_ctrl_reads_zero:
      assert property (rd_ack && avs_address == 5'h18 |-> avs_readdata == 32'h00000000)
      else $error("node control did not read zero");
   a_read_width:
      assert property (rd_ack |-> avs_readdata[31:9] == 23'h000000)
      else $error("read data beyond register width");
endmodule
bind bnip_top bnip_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .master_role(master_role), .irq(irq));

//--- tb/bnip_top_tb.sv
// Self-checking bench for the pending-flag block
`timescale 1ns/10ps
module bnip_top_tb;
   reg core_clk = 1'b0;
   reg rst_b = 1'b0;
   reg [4:0] addr = 5'h00;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wdata = 32'h00000000;
   reg [3:0] be = 4'hF;
   reg master_role = 1'b1;
   reg [7:0] ev = 8'h00;
   reg slot = 1'b1;
   reg [7:0] gpio = 8'h00;
   wire [31:0] rdata;
   wire wait_r;
   wire irq;
   integer err_count = 0;
   integer compares = 0;
   integer cyc = 0;
   integer i;
   integer j;
   reg [31:0] q;
   always #2 core_clk = ~core_clk;
   bnip_top dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wait_r), .master_role(master_role), .missed_frame_evt(ev[6]),
      .link_err_evt(ev[5]), .pwr_switch_err_evt(ev[4]), .parity_err_evt(ev[3]),
      .decode_err_evt(ev[1]), .slot_consumed(slot), .resp_frame_crc_evt(ev[7]),
      .ctrl_frame_crc_evt(ev[2]), .header_count_err_evt(ev[0]), .gpio_pin(gpio), .irq(irq));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task print_verdict;
      begin
         $display("errors %0d compares %0d", err_count, compares);
         if (err_count == 0 && compares > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Event e stands from the request up to the answering edge
   task bus(input w, input [4:0] a, input [31:0] d, input [7:0] e);
      integer n;
      begin
         n = 0;
         @(posedge core_clk);
         addr <= a;
         wdata <= d;
         rd <= !w;
         wr <= w;
         ev <= e;
         @(posedge core_clk);
         while (wait_r !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n = n + 1;
         end
         if (n >= 50) cmp(32'hFFFFFFFF, 32'h0);
         q = rdata;
         rd <= 1'b0;
         wr <= 1'b0;
         ev <= 8'h00;
      end
   endtask
   task wr32(input [4:0] a, input [31:0] d);
      bus(1'b1, a, d, 8'h00);
   endtask
   task chk(input [4:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0, 8'h00);
         cmp(q, exp);
      end
   endtask
   task pulse(input [7:0] e);
      begin
         @(posedge core_clk);
         ev <= e;
         @(posedge core_clk);
         ev <= 8'h00;
      end
   endtask
   task chk_irq(input exp);
      begin
         @(negedge core_clk);
         cmp({31'h0, irq}, {31'h0, exp});
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      begin
         for (i = 0; i < 8; i = i + 1) chk(i * 4, 32'h0);
         chk(5'h02, 32'h0);
         chk_irq(1'b0);
      end
   endtask
   task t_link;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            if (i != 5) begin
               master_role <= !(i == 2 || i == 7);
               pulse(8'h01 << i);
               chk(5'h00, 32'h1 << i);
               wr32(5'h00, 32'h1 << i);
               chk(5'h00, 32'h0);
            end
         end
         slot <= 1'b0;
         pulse(8'h0A);
         chk(5'h00, 32'h0);
         slot <= 1'b1;
         master_role <= 1'b1;
         pulse(8'h84);
         chk(5'h00, 32'h04);
         wr32(5'h00, 32'hFF);
      end
   endtask
   task t_thresh;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wr32(5'h10, i << 5);
            wr32(5'h14, 32'h0);
            for (j = 1; j < (2 << i); j = j + 1) pulse(8'h20);
            chk(5'h00, 32'h0);
            pulse(8'h20);
            chk(5'h00, 32'h20);
            wr32(5'h00, 32'h20);
         end
      end
   endtask
   task t_w1c;
      begin
         pulse(8'h40);
         wr32(5'h00, 32'h0);
         chk(5'h00, 32'h40);
         wr32(5'h00, 32'hBF);
         chk(5'h00, 32'h40);
         bus(1'b1, 5'h00, 32'h40, 8'h40);
         chk(5'h00, 32'h40);
         be <= 4'h0;
         wr32(5'h00, 32'h40);
         be <= 4'hF;
         chk(5'h00, 32'h40);
         wr32(5'h00, 32'h40);
         chk(5'h00, 32'h0);
      end
   endtask
   task t_irq;
      begin
         pulse(8'h10);
         chk(5'h00, 32'h10);
         chk_irq(1'b0);
         wr32(5'h08, 32'h10);
         chk_irq(1'b1);
         chk(5'h1C, 32'h1);
         wr32(5'h08, 32'h0);
         chk_irq(1'b0);
         wr32(5'h08, 32'h10);
         wr32(5'h00, 32'h10);
         chk_irq(1'b0);
         wr32(5'h08, 32'h0);
      end
   endtask
   task t_pins;
      begin
         master_role <= 1'b0;
         wr32(5'h0C, 32'hFF);
         for (i = 0; i < 8; i = i + 1) begin
            @(posedge core_clk);
            gpio <= gpio | (8'h01 << i);
            repeat (8) @(posedge core_clk);
            chk(5'h04, (i == 1) ? 32'h0 : 32'h1 << i);
            chk_irq(i != 1);
            wr32(5'h04, 32'hFF);
         end
         gpio <= 8'h00;
         repeat (8) @(posedge core_clk);
         master_role <= 1'b1;
         gpio <= 8'h01;
         repeat (8) @(posedge core_clk);
         chk(5'h04, 32'h0);
         wr32(5'h0C, 32'h0);
      end
   endtask
   task t_soft;
      begin
         pulse(8'h41);
         wr32(5'h08, 32'hFF);
         wr32(5'h10, 32'hE0);
         wr32(5'h18, 32'h1);
         chk(5'h00, 32'h0);
         chk(5'h08, 32'h0);
         chk(5'h10, 32'h0);
      end
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset;
      t_link;
      t_thresh;
      t_w1c;
      t_irq;
      t_pins;
      t_soft;
      print_verdict;
   end
endmodule
